// ### jtp_pkg.sv
package jtp_pkg;

   // instruction register
   localparam int          IR_LEN     = 3;
   localparam logic [2:0]  OP_EXTEST  = 3'h0;
   localparam logic [2:0]  OP_SAMPLE  = 3'h1;
   localparam logic [2:0]  OP_HIGHZ   = 3'h2;
   localparam logic [2:0]  OP_CLAMP   = 3'h3;
   localparam logic [2:0]  OP_IDCODE  = 3'h6;
   localparam logic [2:0]  OP_BYPASS  = 3'h7;
   localparam logic [2:0]  IR_CAPTURE = 3'h4;

   // identification word layout; field values are arbitrary
   localparam int          ID_LEN      = 32;
   localparam logic        ID_FIXED    = 1'h1;
   localparam logic [10:0] ID_MFR_DEF  = 11'h2A5;
   localparam logic [15:0] ID_PART_DEF = 16'h5A5A;
   localparam logic [3:0]  ID_VER_DEF  = 4'h1;

   // boundary register and reset entry
   localparam int          BSR_LEN_DEF   = 77;
   localparam logic [2:0]  TLR_TMS_EDGES = 3'h5;

   typedef enum logic [3:0]
   {
      ST_RESET,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SH_DR,
      ST_EX1_DR,
      ST_PAU_DR,
      ST_EX2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SH_IR,
      ST_EX1_IR,
      ST_PAU_IR,
      ST_EX2_IR,
      ST_UPD_IR
   } jtp_state_type;

   typedef enum logic [1:0]
   {
      DR_BYP,
      DR_ID,
      DR_BSR
   } jtp_dr_type;

   typedef struct packed
   {
      logic test_drive;
      logic highz;
   } jtp_mode_type;

endpackage

// ### jtp_sync.sv
`timescale 1ns/10ps
// two-stage level synchroniser; first stage feeds only the second
module jtp_sync
#(
   parameter int WIDTH = 1
)
(
   // clocking
   input  wire logic             clock,
   input  wire logic             en,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clock)
   begin
      if (en)
      begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

// ### jtp_tap.sv
`timescale 1ns/10ps
module jtp_tap
   import jtp_pkg::*;
#(
   parameter int          BSR_LEN = jtp_pkg::BSR_LEN_DEF,
   // identification fields; values are arbitrary
   parameter logic [10:0] ID_MFR  = jtp_pkg::ID_MFR_DEF,
   parameter logic [15:0] ID_PART = jtp_pkg::ID_PART_DEF,
   parameter logic [3:0]  ID_VER  = jtp_pkg::ID_VER_DEF
)
(
   // system side
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic                  clk_en,
   input  wire logic [BSR_LEN-1:0]    pin_level,
   output jtp_pkg::jtp_mode_type      sys_mode,
   // test port
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo_o,
   output logic                       tdo_oe,
   // boundary register and state view, tck domain
   output logic [BSR_LEN-1:0]         bsr_pout,
   output jtp_pkg::jtp_state_type     tap_state
);

   import jtp_pkg::*;

   localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VER, ID_PART, ID_MFR, ID_FIXED};

   logic                tck_rst_n;
   jtp_state_type       state_ff;
   jtp_state_type       nxt_state;
   logic [IR_LEN-1:0]   ir_sr_ff;
   logic [IR_LEN-1:0]   cur_ir_ff;
   logic                byp_ff;
   logic [ID_LEN-1:0]   id_sr_ff;
   logic [BSR_LEN-1:0]  bsr_sr_ff;
   logic [BSR_LEN-1:0]  pin_sync;
   jtp_dr_type          dr_sel;
   jtp_mode_type        tck_mode_ff;
   jtp_mode_type        mode_sync;
   logic [2:0]          tms_hi_cnt_ff;

   function automatic jtp_dr_type dr_of(input logic [IR_LEN-1:0] ir);
      case (ir)
         OP_EXTEST: dr_of = DR_BSR;
         OP_SAMPLE: dr_of = DR_BSR;
         OP_IDCODE: dr_of = DR_ID;
         default:   dr_of = DR_BYP;
      endcase
   endfunction

   function automatic jtp_mode_type mode_of(input logic [IR_LEN-1:0] ir);
      mode_of.test_drive = (ir == OP_EXTEST) || (ir == OP_CLAMP);
      mode_of.highz      = (ir == OP_HIGHZ);
   endfunction

   assign dr_sel    = dr_of(cur_ir_ff);
   assign tap_state = state_ff;

   // crossings into the tck domain
   jtp_sync #(.WIDTH(1)) u_rst_sync
   (
      .clock (tck),
      .en    (1'b1),
      .d     (rst_n),
      .q     (tck_rst_n)
   );

   jtp_sync #(.WIDTH(BSR_LEN)) u_pin_sync
   (
      .clock (tck),
      .en    (1'b1),
      .d     (pin_level),
      .q     (pin_sync)
   );

   // mode level back into the system domain
   jtp_sync #(.WIDTH($bits(jtp_mode_type))) u_mode_sync
   (
      .clock (clock),
      .en    (clk_en),
      .d     (tck_mode_ff),
      .q     (mode_sync)
   );

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         sys_mode <= '0;
      else if (clk_en)
         sys_mode <= mode_sync;
   end

   // next state
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RESET:  nxt_state = tms ? ST_RESET  : ST_IDLE;
         ST_IDLE:   nxt_state = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: nxt_state = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: nxt_state = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: nxt_state = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: nxt_state = tms ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: nxt_state = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: nxt_state = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: nxt_state = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
         default:   nxt_state = ST_RESET;
      endcase
   end

   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         state_ff <= ST_RESET;
      else
         state_ff <= nxt_state;
   end

   // instruction shifter
   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         ir_sr_ff <= IR_CAPTURE;
      else if (state_ff == ST_CAP_IR)
         ir_sr_ff <= IR_CAPTURE;
      else if (state_ff == ST_SH_IR)
         ir_sr_ff <= {tdi, ir_sr_ff[IR_LEN-1:1]};
   end

   // current instruction, latched on the falling edge
   always_ff @(negedge tck)
   begin
      if (!tck_rst_n || state_ff == ST_RESET)
         cur_ir_ff <= OP_IDCODE;
      else if (state_ff == ST_UPD_IR)
         cur_ir_ff <= ir_sr_ff;
   end

   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         tck_mode_ff <= '0;
      else
         tck_mode_ff <= mode_of(cur_ir_ff);
   end

   // bypass stage has no parallel input
   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         byp_ff <= 1'h0;
      else if (state_ff == ST_SH_DR && dr_sel == DR_BYP)
         byp_ff <= tdi;
   end

   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         id_sr_ff <= ID_VALUE;
      else if (state_ff == ST_CAP_DR && dr_sel == DR_ID)
         id_sr_ff <= ID_VALUE;
      else if (state_ff == ST_SH_DR && dr_sel == DR_ID)
         id_sr_ff <= {tdi, id_sr_ff[ID_LEN-1:1]};
   end

   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         bsr_sr_ff <= '0;
      else if (state_ff == ST_CAP_DR && dr_sel == DR_BSR)
         bsr_sr_ff <= pin_sync;
      else if (state_ff == ST_SH_DR && dr_sel == DR_BSR)
         bsr_sr_ff <= {tdi, bsr_sr_ff[BSR_LEN-1:1]};
   end

   // parallel output stays put while shifting
   always_ff @(negedge tck)
   begin
      if (!tck_rst_n)
         bsr_pout <= '0;
      else if (state_ff == ST_UPD_DR && dr_sel == DR_BSR)
         bsr_pout <= bsr_sr_ff;
   end

   // serial output on the falling edge
   always_ff @(negedge tck)
   begin
      if (!tck_rst_n)
      begin
         tdo_o  <= 1'h0;
         tdo_oe <= 1'h0;
      end
      else
      begin
         tdo_oe <= (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR);
         if (state_ff == ST_SH_IR)
            tdo_o <= ir_sr_ff[0];
         else if (state_ff == ST_SH_DR)
         begin
            case (dr_sel)
               DR_ID:   tdo_o <= id_sr_ff[0];
               DR_BSR:  tdo_o <= bsr_sr_ff[0];
               default: tdo_o <= byp_ff;
            endcase
         end
      end
   end

   // consecutive tms-high edges, for checking only
   always_ff @(posedge tck)
   begin
      if (!tck_rst_n)
         tms_hi_cnt_ff <= 3'h0;
      else if (!tms)
         tms_hi_cnt_ff <= 3'h0;
      else if (tms_hi_cnt_ff < TLR_TMS_EDGES)
         tms_hi_cnt_ff <= tms_hi_cnt_ff + 3'h1;
   end

   sequence s_dr_entry;
      (state_ff == ST_SEL_DR && !tms) ##1 (state_ff == ST_CAP_DR && !tms);
   endsequence

   sequence s_ir_entry;
      (state_ff == ST_SEL_IR && !tms) ##1 (state_ff == ST_CAP_IR && !tms);
   endsequence

   property p_reset_reach;
      @(posedge tck) disable iff (!tck_rst_n)
      tms_hi_cnt_ff >= TLR_TMS_EDGES |-> state_ff == ST_RESET;
   endproperty
   a_reset_reach: assert property (p_reset_reach)
      else $error("five tms-high edges did not reach reset");

   property p_reset_mode;
      @(posedge tck) disable iff (!tck_rst_n)
      (state_ff == ST_RESET)[*3] |-> cur_ir_ff == OP_IDCODE && !tck_mode_ff.test_drive;
   endproperty
   a_reset_mode: assert property (p_reset_mode)
      else $error("reset state left test logic active");

   property p_idle_hold;
      @(posedge tck) disable iff (!tck_rst_n)
      state_ff == ST_IDLE && !tms |=>
         state_ff == ST_IDLE && $stable(cur_ir_ff) && $stable(bsr_sr_ff);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("idle did not hold");

   property p_dr_entry;
      @(posedge tck) disable iff (!tck_rst_n)
      s_dr_entry |=> state_ff == ST_SH_DR;
   endproperty
   a_dr_entry: assert property (p_dr_entry)
      else $error("data scan entry went wrong");

   property p_ir_entry;
      @(posedge tck) disable iff (!tck_rst_n)
      s_ir_entry |=> state_ff == ST_SH_IR && ir_sr_ff == IR_CAPTURE;
   endproperty
   a_ir_entry: assert property (p_ir_entry)
      else $error("instruction scan entry went wrong");

   property p_capture_pins;
      @(posedge tck) disable iff (!tck_rst_n)
      state_ff == ST_CAP_DR && (cur_ir_ff == OP_EXTEST || cur_ir_ff == OP_SAMPLE)
         |=> bsr_sr_ff == $past(pin_sync);
   endproperty
   a_capture_pins: assert property (p_capture_pins)
      else $error("boundary capture missed pin levels");

   property p_id_shift;
      @(posedge tck) disable iff (!tck_rst_n)
      state_ff == ST_SH_DR && dr_sel == DR_ID
         |=> id_sr_ff == {$past(tdi), $past(id_sr_ff[ID_LEN-1:1])};
   endproperty
   a_id_shift: assert property (p_id_shift)
      else $error("identification shift wrong");

   property p_pause_hold;
      @(posedge tck) disable iff (!tck_rst_n)
      (state_ff == ST_PAU_DR || state_ff == ST_PAU_IR) |=>
         $stable(bsr_sr_ff) && $stable(id_sr_ff) && $stable(ir_sr_ff);
   endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("pause did not hold registers");

   property p_pout_only_update;
      @(posedge tck) disable iff (!tck_rst_n)
      !(state_ff == ST_UPD_DR && dr_sel == DR_BSR) |-> $stable(bsr_pout);
   endproperty
   a_pout_only_update: assert property (p_pout_only_update)
      else $error("boundary output changed outside update");

   property p_ir_stable;
      @(posedge tck) disable iff (!tck_rst_n)
      state_ff != ST_UPD_IR && state_ff != ST_RESET |-> $stable(cur_ir_ff);
   endproperty
   a_ir_stable: assert property (p_ir_stable)
      else $error("instruction changed outside update");

   property p_ir_update;
      @(posedge tck) disable iff (!tck_rst_n)
      state_ff == ST_UPD_IR |=> cur_ir_ff == $past(ir_sr_ff);
   endproperty
   a_ir_update: assert property (p_ir_update)
      else $error("instruction not latched in update");

   property p_tdo_enable;
      @(posedge tck) disable iff (!tck_rst_n)
      tck_rst_n |-> tdo_oe == (state_ff == ST_SH_DR || state_ff == ST_SH_IR);
   endproperty
   a_tdo_enable: assert property (p_tdo_enable)
      else $error("tdo enable outside shift");

   property p_exit_dr;
      @(posedge tck) disable iff (!tck_rst_n)
      (state_ff == ST_EX1_DR || state_ff == ST_EX2_DR) && tms |=> state_ff == ST_UPD_DR;
   endproperty
   a_exit_dr: assert property (p_exit_dr)
      else $error("exit did not reach update");

   property p_update_next;
      @(posedge tck) disable iff (!tck_rst_n)
      (state_ff == ST_UPD_DR || state_ff == ST_UPD_IR)
         |=> state_ff == ($past(tms) ? ST_SEL_DR : ST_IDLE);
   endproperty
   a_update_next: assert property (p_update_next)
      else $error("update left to wrong state");

endmodule

// ### jtp_tester.sv
`timescale 1ns/10ps
// tester side of the test port; tck toggles only inside tick and rests low between
module jtp_tester
(
   // test port
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo_o,
   input  wire logic tdo_oe
);
   initial
   begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end

   // one 6 ns tck period; tdo and its enable are read at the rising edge
   task automatic tick(input logic m, input logic d, output logic b, output logic oe);
      tms <= m;
      tdi <= d;
      #3;
      tck <= 1'h1;
      b = tdo_o;
      oe = tdo_oe;
      #3;
      tck <= 1'h0;
   endtask
endmodule

// ### tb_jtag_tap_state_machine.sv
`timescale 1ns/10ps
module tb_jtag_tap_state_machine;
   import jtp_pkg::*;
   localparam int BL = 8;
   logic          clock = 1'h0;
   logic          rst_n = 1'h0;
   logic          clk_en = 1'h1;
   logic [BL-1:0] pin_level = '0;
   jtp_mode_type  sys_mode;
   logic          tck;
   logic          tms;
   logic          tdi;
   logic          tdo_o;
   logic          tdo_oe;
   logic [BL-1:0] bsr_pout;
   jtp_state_type tap_state;
   int            failures = 0;
   int            compares = 0;
   int            cycles = 0;
   logic [31:0]   seed = 32'hDC82;
   int            st = 0;
   logic          dq[$];
   logic          iq[$];
   logic [2:0]    ir_cur = OP_IDCODE;
   logic          byp = 1'hx;
   logic [BL-1:0] bsr_exp = '0;
   logic [BL-1:0] pins = '0;
   logic [2:0]    ops[7];
   int            n0[16];
   int            n1[16];

   jtp_tap #(.BSR_LEN(BL)) jtp_tap_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .pin_level(pin_level), .sys_mode(sys_mode), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe), .bsr_pout(bsr_pout), .tap_state(tap_state));
   jtp_tester jtp_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

   always #5 clock = ~clock;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic rbit();
      logic [31:0] r;
      r = rnd();
      return r[0];
   endfunction

   // 2 boundary register, 1 identification, 0 bypass
   function automatic int sel();
      if (ir_cur == OP_EXTEST || ir_cur == OP_SAMPLE)
         return 2;
      return (ir_cur == OP_IDCODE) ? 1 : 0;
   endfunction

   task automatic wrap_up();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clock)
   begin
      clk_en <= (rnd() & 32'h3) != 32'h0;
      cycles++;
      if (cycles == 50000)
      begin
         failures++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic capture();
      logic [31:0] w;
      w = {ID_VER_DEF, ID_PART_DEF, ID_MFR_DEF, ID_FIXED};
      dq = {};
      if (sel() == 0)
         dq.push_back(byp);
      for (int i = 0; i < 32 && sel() == 1; i++)
         dq.push_back(w[i]);
      for (int i = 0; i < BL && sel() == 2; i++)
         dq.push_back(pins[i]);
   endtask

   // one tck period, then the model follows the same edge
   task automatic step(input logic m, input logic d);
      logic b;
      logic oe;
      int   p;
      p = st;
      jtp_tester_i.tick(m, d, b, oe);
      st = m ? n1[p] : n0[p];
      chk(oe, (p == 4) || (p == 11));
      if (p == 0)
         ir_cur = OP_IDCODE;
      if (p == 3)
         capture();
      if (p == 10)
         iq = {1'h0, 1'h0, 1'h1};
      if (p == 4)
      begin
         if (dq[0] !== 1'hx)
            chk(b, dq[0]);
         dq.push_back(d);
         void'(dq.pop_front());
         if (sel() == 0)
            byp = dq[0];
      end
      if (p == 11)
      begin
         chk(b, iq[0]);
         iq.push_back(d);
         void'(iq.pop_front());
      end
      if (p == 8 && sel() == 2)
         for (int i = 0; i < BL; i++)
            bsr_exp[i] = dq[i];
      if (p == 15)
         ir_cur = {iq[2], iq[1], iq[0]};
      chk(tap_state, st);
      chk(bsr_pout, bsr_exp);
   endtask

   task automatic scan(input logic ir, input int len, input logic [31:0] v, input int pz);
      step(1'h1, 1'h0);
      if (ir)
         step(1'h1, 1'h0);
      step(1'h0, 1'h0);
      step(1'h0, 1'h0);
      for (int i = 0; i < len; i++)
      begin
         step(i == len - 1 || i == pz, v[i]);
         if (i == pz && i < len - 1)
         begin
            step(1'h0, 1'h1);
            step(1'h0, 1'h0);
            step(1'h1, 1'h1);
            step(1'h0, 1'h0);
         end
      end
      step(1'h1, 1'h0);
      step(1'h0, 1'h0);
   endtask

   task automatic sys_chk();
      repeat (40) @(posedge clock);
      chk(sys_mode, {30'h0, ir_cur == OP_EXTEST || ir_cur == OP_CLAMP, ir_cur == OP_HIGHZ});
   endtask

   initial
   begin
      logic b;
      logic oe;
      n0 = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
      n1 = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
      ops = '{OP_SAMPLE, OP_EXTEST, OP_HIGHZ, OP_CLAMP, 3'h5, OP_BYPASS, OP_EXTEST};
      fork
         repeat (11) @(posedge clock);
         repeat (18) jtp_tester_i.tick(1'h1, 1'h0, b, oe);
      join
      @(posedge clock);
      rst_n <= 1'h1;
      repeat (3) step(1'h1, rbit());
      step(1'h0, rbit());
      step(1'h0, rbit());
      scan(1'h0, 32, rnd(), 9);
      for (int k = 0; k < 7; k++)
      begin
         @(posedge clock);
         pins = BL'(rnd());
         pin_level <= pins;
         repeat (5) @(posedge clock);
         scan(1'h1, IR_LEN, {29'h0, ops[k]}, k);
         sys_chk();
         scan(1'h0, 32, rnd(), 3);
      end
      step(1'h1, 1'h0);
      step(1'h0, 1'h0);
      step(1'h0, 1'h0);
      repeat (5) step(1'h1, rbit());
      chk(tap_state, ST_RESET);
      step(1'h1, 1'h0);
      sys_chk();
      step(1'h0, 1'h0);
      scan(1'h0, 32, rnd(), 40);
      repeat (400) step(rbit(), rbit());
      wrap_up();
   end
endmodule
